// >>> lnbsi_host.sv
// bus controller model for the supply controller's register port
// assumes a pulled-up data wire resolved by the bench; clk is MCLK
`timescale 1ns/1ps
module lnbsi_host (
  // clock
  input wire logic clk,
  // bus
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // bus idles released; clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // data moves mid low phase, sampled at end of high phase
  task automatic pulse(input logic pull, output logic seen);
    scl <= 1'b0;
    tick(2);
    sda_pull <= pull;
    tick(2);
    scl <= 1'b1;
    tick(4);
    seen = sda;
  endtask : pulse

  task automatic start;
    sda_pull <= 1'b1;
    tick(4);
  endtask : start

  task automatic stop;
    scl <= 1'b0;
    tick(2);
    sda_pull <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b0;
    tick(8);
  endtask : stop

  // ninth clock always given, ack only reported
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(~b[i], s);
    end
    pulse(1'b0, s);
    ack = ~s;
  endtask : send_byte

  // raw flags returned; masking left to caller
  task automatic recv_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b0, b[i]);
    end
    pulse(more, s);
  endtask : recv_byte
endmodule : lnbsi_host

// >>> lnbsi_pkg.sv
// constants and types of the supply controller's serial register port
// assumes one 8-bit register and a 7-bit two-wire target address
package lnbsi_pkg;

  // ****************************************
  // address
  // ****************************************
  localparam logic [5:0] ADDR_UPPER = 6'h05;

  // ****************************************
  // system_reg layout, write side
  // ****************************************
  localparam int unsigned BIT_CUR_STATIC = 7;
  localparam int unsigned BIT_TONE_TX = 6;
  localparam int unsigned BIT_TONE_FORCE = 5;
  localparam int unsigned BIT_LINE_LOSS = 4;
  localparam int unsigned BIT_VOLT_HIGH = 3;
  localparam int unsigned BIT_POWER_ON = 2;
  localparam int unsigned BIT_MIN_CUR = 1;
  localparam int unsigned BIT_BOOST = 0;

  // ****************************************
  // system_reg layout, read side
  // ****************************************
  localparam int unsigned BIT_LOW_CUR_FLAG = 7;
  localparam int unsigned BIT_VOLT_FLAG = 6;
  localparam int unsigned BIT_TONE_FLAG = 5;
  localparam int unsigned BIT_OVER_TEMP = 1;
  localparam int unsigned BIT_OVERLOAD = 0;

  localparam logic [7:0] SYSTEM_REG_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int unsigned SYNC_WIDTH = 10;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    LEVEL_OFF,
    LEVEL_13V4,
    LEVEL_18V5,
    LEVEL_14V4,
    LEVEL_19V5,
    LEVEL_22V
  } lnbsi_level_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK
  } lnbsi_state_e;

endpackage : lnbsi_pkg

// >>> lnbsi_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes each bit is an independent level from outside the MCLK domain
`timescale 1ns/1ps
module lnbsi_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } lnbsi_sync_s;

  lnbsi_sync_s r;
  lnbsi_sync_s next_r;

  // first stage is read by the second stage only
  always_comb begin
    next_r = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;

endmodule : lnbsi_sync

// >>> lnbsi_top.sv
// two-wire register port of a dish supply and tone controller
// assumes SCL/SDA and all status pins are asynchronous to MCLK,
// with SCL at least eight MCLK periods long
//
// Functional notes
// [RULE1] transaction: start, address byte with read bit, acked bytes, stop
// [RULE2] address is 000101 plus the address-select pin level
// [RULE3] one control byte with eight fixed-position write bits
// [RULE4] read byte: three flags, three control copies, two flags
// [RULE5] all register bits are zero after reset
// [RULE6] a write data byte replaces all eight control bits
// [RULE7] power off disables output; else two bits pick one of four levels
// [RULE8] boost bit with power on forces the 22 V level
// [RULE9] tone gated by pin, or continuous when forced, if path enabled
// [RULE10] tone path bit switches the tone transmit output only (here it also gates TONE_ENABLE)
// [RULE11] limit style bit: zero pulsed, one static
// [RULE12] min current bit picks the low or high threshold
// [RULE13] read data leaves msb first on controller clocks
// [RULE14] controller ack asks another byte, nack ends the read
// [RULE15] read-back control copies equal the last written values
// [RULE16] flags read zero normally and one while a fault is present
// [RULE17] over temperature flag set disables power
// [RULE18] overload flag follows the overload protection input
// [RULE19] monitor flags read one while out of limits
// [RULE20] host ignores some flags in some modes
// [RULE21] in lockout bus is ignored and register held at zero
// [RULE22] controller may skip checking acks
// [RULE23] ack every received byte when addressed, never in lockout
// [RULE24] bytes are eight bits msb first plus one ack bit
// [RULE25] foreign address: data line released, bytes ignored
`timescale 1ns/1ps
module lnbsi_top (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // two-wire bus
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // pins and analog status
  input wire logic ADDR_SEL,
  input wire logic TONE_GATE_INPUT,
  input wire logic UNDERVOLTAGE_LOCKOUT,
  input wire logic LOW_CURRENT_FAULT,
  input wire logic VOLTAGE_FAULT,
  input wire logic TONE_FAULT,
  input wire logic OVER_TEMP,
  input wire logic OVERLOAD,
  // controls to the analog blocks
  output logic POWER_EN,
  output logic [2:0] OUT_LEVEL,
  output logic LINE_LOSS_COMP,
  output logic VOLT_HIGH_SEL,
  output logic EXTRA_BOOST,
  output logic TONE_ENABLE,
  output logic TONE_TX_OUT_EN,
  output logic CURRENT_LIMIT_STATIC,
  output logic MIN_CURRENT_HIGH,
  // register view
  output logic [7:0] SYSTEM_REG
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    lnbsi_pkg::lnbsi_state_e st;
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic ack_seen;
    logic sda_oe;
    logic [7:0] ctrl;
    lnbsi_pkg::lnbsi_level_e level;
    logic power_en;
    logic tone_en;
  } lnbsi_top_s;

  lnbsi_top_s r;
  lnbsi_top_s next_r;

  logic [lnbsi_pkg::SYNC_WIDTH-1:0] sync_q;
  logic scl;
  logic sda;
  logic addr_sel;
  logic tone_gate;
  logic uvlo;
  logic [4:0] flt;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic addr_hit;

  // ****************************************
  // pin synchronisers
  // ****************************************
  lnbsi_sync #(
    .WIDTH(lnbsi_pkg::SYNC_WIDTH)
  ) u_sync (
    .clk(MCLK),
    .rst(RST),
    .d({SCL_I, SDA_I, ADDR_SEL, TONE_GATE_INPUT, UNDERVOLTAGE_LOCKOUT,
        LOW_CURRENT_FAULT, VOLTAGE_FAULT, TONE_FAULT, OVER_TEMP,
        OVERLOAD}),
    .q(sync_q)
  );

  assign {scl, sda, addr_sel, tone_gate, uvlo, flt} = sync_q;

  // ****************************************
  // helpers
  // ****************************************
  // live flags, so a cleared fault reads zero again at once
  function automatic logic [7:0] read_byte(input logic [7:0] c,
                                           input logic [4:0] f);
    logic [7:0] b;
    b = 8'h00;
    b[lnbsi_pkg::BIT_LOW_CUR_FLAG] = f[4]; // RULE19
    b[lnbsi_pkg::BIT_VOLT_FLAG] = f[3]; // RULE19
    b[lnbsi_pkg::BIT_TONE_FLAG] = f[2]; // RULE19
    b[lnbsi_pkg::BIT_LINE_LOSS] = c[lnbsi_pkg::BIT_LINE_LOSS]; // RULE15
    b[lnbsi_pkg::BIT_VOLT_HIGH] = c[lnbsi_pkg::BIT_VOLT_HIGH]; // RULE15
    b[lnbsi_pkg::BIT_POWER_ON] = c[lnbsi_pkg::BIT_POWER_ON]; // RULE15
    b[lnbsi_pkg::BIT_OVER_TEMP] = f[1]; // RULE17
    b[lnbsi_pkg::BIT_OVERLOAD] = f[0]; // RULE18
    return b; // RULE4 RULE16
  endfunction : read_byte

  assign scl_rise = scl & ~r.scl_q;
  assign scl_fall = ~scl & r.scl_q;
  assign start_c = r.scl_q & scl & r.sda_q & ~sda; // RULE1
  assign stop_c = r.scl_q & scl & ~r.sda_q & sda; // RULE1
  assign addr_hit = (r.sh[7:1] == {lnbsi_pkg::ADDR_UPPER, addr_sel}); // RULE2

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] rb;
    logic [7:0] c;
    rb = read_byte(r.ctrl, flt);
    c = r.ctrl;
    next_r = r;
    next_r.scl_q = scl;
    next_r.sda_q = sda;
    if (start_c) begin
      next_r.st = lnbsi_pkg::ST_ADDR;
      next_r.cnt = 4'h0;
      next_r.sda_oe = 1'b0;
    end else if (stop_c) begin
      next_r.st = lnbsi_pkg::ST_IDLE;
      next_r.sda_oe = 1'b0;
    end else begin
      case (r.st)
        lnbsi_pkg::ST_IDLE: begin
          next_r.sda_oe = 1'b0;
        end
        lnbsi_pkg::ST_ADDR, lnbsi_pkg::ST_WRITE: begin
          if (scl_rise && r.cnt != lnbsi_pkg::BITS_PER_BYTE) begin
            next_r.sh = {r.sh[6:0], sda}; // RULE24
            next_r.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == lnbsi_pkg::BITS_PER_BYTE) begin
            next_r.cnt = 4'h0;
            if (r.st == lnbsi_pkg::ST_WRITE) begin
              next_r.ctrl = r.sh; // RULE6
              next_r.sda_oe = 1'b1; // RULE23
              next_r.st = lnbsi_pkg::ST_WRITE_ACK;
            end else if (addr_hit) begin
              next_r.rw = r.sh[0]; // RULE1
              next_r.sda_oe = 1'b1; // RULE23
              next_r.st = lnbsi_pkg::ST_ADDR_ACK;
            end else begin
              next_r.st = lnbsi_pkg::ST_IDLE; // RULE25
            end
          end
        end
        lnbsi_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (r.rw) begin
              next_r.sh = rb; // RULE13
              next_r.sda_oe = ~rb[7];
              next_r.st = lnbsi_pkg::ST_READ;
            end else begin
              next_r.sda_oe = 1'b0;
              next_r.st = lnbsi_pkg::ST_WRITE;
            end
          end
        end
        lnbsi_pkg::ST_WRITE_ACK: begin
          if (scl_fall) begin
            next_r.sda_oe = 1'b0;
            next_r.st = lnbsi_pkg::ST_WRITE;
          end
        end
        lnbsi_pkg::ST_READ: begin
          if (scl_fall) begin
            if (r.cnt == lnbsi_pkg::BITS_PER_BYTE - 4'h1) begin
              next_r.sda_oe = 1'b0;
              next_r.cnt = 4'h0;
              next_r.st = lnbsi_pkg::ST_READ_ACK;
            end else begin
              next_r.sh = {r.sh[6:0], 1'b0}; // RULE13
              next_r.sda_oe = ~r.sh[6];
              next_r.cnt = r.cnt + 4'h1;
            end
          end
        end
        lnbsi_pkg::ST_READ_ACK: begin
          if (scl_rise) begin
            next_r.ack_seen = ~sda;
          end else if (scl_fall) begin
            if (r.ack_seen) begin
              next_r.sh = rb; // RULE14
              next_r.sda_oe = ~rb[7];
              next_r.st = lnbsi_pkg::ST_READ;
            end else begin
              next_r.st = lnbsi_pkg::ST_IDLE; // RULE14
            end
          end
        end
        default: begin
          next_r.st = lnbsi_pkg::ST_IDLE;
          next_r.sda_oe = 1'b0;
        end
      endcase
    end
    // lockout wins over any bus activity
    if (uvlo) begin
      next_r.st = lnbsi_pkg::ST_IDLE; // RULE21
      next_r.sda_oe = 1'b0; // RULE23
      next_r.ctrl = lnbsi_pkg::SYSTEM_REG_RESET; // RULE21
    end
    // decoded controls, one cycle behind the register
    if (!c[lnbsi_pkg::BIT_POWER_ON]) begin
      next_r.level = lnbsi_pkg::LEVEL_OFF; // RULE7
    end else if (c[lnbsi_pkg::BIT_BOOST]) begin
      next_r.level = lnbsi_pkg::LEVEL_22V; // RULE8
    end else begin
      case ({c[lnbsi_pkg::BIT_LINE_LOSS], c[lnbsi_pkg::BIT_VOLT_HIGH]})
        2'h0: next_r.level = lnbsi_pkg::LEVEL_13V4; // RULE7
        2'h1: next_r.level = lnbsi_pkg::LEVEL_18V5;
        2'h2: next_r.level = lnbsi_pkg::LEVEL_14V4;
        default: next_r.level = lnbsi_pkg::LEVEL_19V5;
      endcase
    end
    // thermal shutdown is immediate, not waiting for software
    next_r.power_en = c[lnbsi_pkg::BIT_POWER_ON] & ~flt[1]; // RULE17
    next_r.tone_en = c[lnbsi_pkg::BIT_TONE_TX] &
                     (c[lnbsi_pkg::BIT_TONE_FORCE] | tone_gate); // RULE9
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      r <= '0; // RULE5
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign SDA_O = 1'b0;
  assign SDA_OE = r.sda_oe;
  assign POWER_EN = r.power_en;
  assign OUT_LEVEL = r.level;
  assign LINE_LOSS_COMP = r.ctrl[lnbsi_pkg::BIT_LINE_LOSS];
  assign VOLT_HIGH_SEL = r.ctrl[lnbsi_pkg::BIT_VOLT_HIGH];
  assign EXTRA_BOOST = r.ctrl[lnbsi_pkg::BIT_BOOST];
  assign TONE_ENABLE = r.tone_en;
  assign TONE_TX_OUT_EN = r.ctrl[lnbsi_pkg::BIT_TONE_TX]; // RULE10
  assign CURRENT_LIMIT_STATIC = r.ctrl[lnbsi_pkg::BIT_CUR_STATIC]; // RULE11
  assign MIN_CURRENT_HIGH = r.ctrl[lnbsi_pkg::BIT_MIN_CUR]; // RULE12
  assign SYSTEM_REG = r.ctrl; // RULE3

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  reset_zero_a: assert property ( // RULE5
    $fell(RST) |-> r.ctrl == 8'h00 && !r.sda_oe)
    else $error("register not cleared by reset");

  lockout_clear_a: assert property ( // RULE21
    uvlo |=> r.ctrl == 8'h00 && r.st == lnbsi_pkg::ST_IDLE)
    else $error("lockout did not clear register");

  lockout_ack_a: assert property ( // RULE23
    uvlo [*2] |-> !SDA_OE)
    else $error("data line driven in lockout");

  foreign_addr_a: assert property ( // RULE25
    r.st == lnbsi_pkg::ST_ADDR && scl_fall && !start_c && !stop_c &&
    r.cnt == lnbsi_pkg::BITS_PER_BYTE && !addr_hit
    |=> r.st == lnbsi_pkg::ST_IDLE ##1 !SDA_OE)
    else $error("foreign address not ignored");

  power_off_a: assert property ( // RULE7
    !r.ctrl[lnbsi_pkg::BIT_POWER_ON] [*2] |-> !POWER_EN &&
    OUT_LEVEL == lnbsi_pkg::LEVEL_OFF)
    else $error("output on with power bit clear");

  boost_level_a: assert property ( // RULE8
    r.ctrl[lnbsi_pkg::BIT_POWER_ON] && r.ctrl[lnbsi_pkg::BIT_BOOST]
    |=> OUT_LEVEL == lnbsi_pkg::LEVEL_22V)
    else $error("boost did not select top level");

  tone_force_a: assert property ( // RULE9
    r.ctrl[lnbsi_pkg::BIT_TONE_TX] && r.ctrl[lnbsi_pkg::BIT_TONE_FORCE]
    |=> TONE_ENABLE)
    else $error("forced tone not running");

  tone_path_a: assert property ( // RULE10
    !r.ctrl[lnbsi_pkg::BIT_TONE_TX] |=> !TONE_ENABLE)
    else $error("tone with path disabled");

  thermal_off_a: assert property ( // RULE17
    flt[1] |=> !POWER_EN)
    else $error("power on in over temperature");

  write_store_a: assert property ( // RULE6
    r.st == lnbsi_pkg::ST_WRITE && scl_fall && !start_c && !stop_c &&
    !uvlo && r.cnt == lnbsi_pkg::BITS_PER_BYTE
    |=> r.ctrl == $past(r.sh) && SDA_OE)
    else $error("write byte not stored and acked");

endmodule : lnbsi_top

// >>> lnbsi_top_test.sv
// bench for the supply controller's serial register port
// assumes lnbsi_host as controller and an open-drain data wire
`timescale 1ns/1ps
module lnbsi_top_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic addr_sel = 1'b0;
  logic gate = 1'b0;
  logic undervoltage_lockout = 1'b0;
  logic [4:0] flt = 5'h00;
  logic scl, pull, sda, sda_o, sda_oe, pe, line_loss_comp, vh, bst, tone_force_on, tone_tx_path_en, cls, mch;
  logic [2:0] lvl;
  logic [7:0] sreg;
  logic [10:0] outs;
  int num_errors = 0;
  int comparisons = 0;

  always #20 mclk = ~mclk;
  // pull-up: low if either party pulls
  assign sda = ~(pull | (sda_oe & ~sda_o));
  assign outs = {pe, lvl, line_loss_comp, vh, bst, tone_force_on, tone_tx_path_en, cls, mch};

  lnbsi_host i_lnbsi_host (.clk(mclk), .sda(sda), .scl(scl), .sda_pull(pull));

  lnbsi_top i_lnbsi_top (
    .MCLK(mclk), .RST(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .ADDR_SEL(addr_sel), .TONE_GATE_INPUT(gate),
    .UNDERVOLTAGE_LOCKOUT(undervoltage_lockout), .LOW_CURRENT_FAULT(flt[4]),
    .VOLTAGE_FAULT(flt[3]), .TONE_FAULT(flt[2]), .OVER_TEMP(flt[1]),
    .OVERLOAD(flt[0]), .POWER_EN(pe), .OUT_LEVEL(lvl),
    .LINE_LOSS_COMP(line_loss_comp), .VOLT_HIGH_SEL(vh), .EXTRA_BOOST(bst),
    .TONE_ENABLE(tone_force_on), .TONE_TX_OUT_EN(tone_tx_path_en), .CURRENT_LIMIT_STATIC(cls),
    .MIN_CURRENT_HIGH(mch), .SYSTEM_REG(sreg)
  );

  // ******************
  // helpers
  // ******************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic check(input string what, input logic [10:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : check

  task automatic conclude;
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  function automatic logic [10:0] ctl(input logic [7:0] d, input logic g, ot);
    logic [2:0] l;
    l = d[2] ? (d[0] ? 3'h5 : 3'h1 + {1'b0, d[4], d[3]}) : 3'h0;
    return {d[2] & ~ot, l, d[4], d[3], d[0], d[6] & (d[5] | g), d[6],
            d[7], d[1]};
  endfunction : ctl

  task automatic chk_all(input logic [7:0] d);
    check("system_reg", {3'h0, d}, {3'h0, sreg});
    check("controls", ctl(d, gate, flt[1]), outs);
  endtask : chk_all

  // one write frame, one or two data bytes; unused ack reads as 1
  task automatic wr(input logic x, input logic [7:0] d0, d1, input int n,
                    output logic [2:0] ack);
    ack[0] = 1'b1;
    i_lnbsi_host.start();
    i_lnbsi_host.send_byte({6'h05, x, 1'b0}, ack[2]);
    i_lnbsi_host.send_byte(d0, ack[1]);
    if (n > 1) i_lnbsi_host.send_byte(d1, ack[0]);
    i_lnbsi_host.stop();
  endtask : wr

  // ******************
  // scenarios
  // ******************
  task automatic t_levels;
    logic [7:0] tbl [9] = '{8'h04, 8'h0C, 8'h14, 8'h1C, 8'h1F, 8'h1B,
                            8'hE4, 8'h42, 8'h84};
    logic [2:0] a;
    foreach (tbl[i]) begin
      wr(1'b0, tbl[i], 8'h00, 1, a);
      check("acks", 11'h7, {8'h00, a});
      chk_all(tbl[i]);
    end
    wr(1'b0, 8'hFF, 8'h24, 2, a);
    check("acks", 11'h7, {8'h00, a});
    chk_all(8'h24);
  endtask : t_levels

  task automatic t_tone;
    logic [2:0] a;
    wr(1'b0, 8'h44, 8'h00, 1, a);
    gate <= 1'b1;
    cyc(6);
    chk_all(8'h44);
    gate <= 1'b0;
    cyc(6);
    chk_all(8'h44);
  endtask : t_tone

  task automatic t_read(input logic [4:0] f);
    logic [2:0] a;
    logic [7:0] b0, b1;
    logic ak;
    wr(1'b0, 8'h1C, 8'h00, 1, a);
    flt <= f;
    cyc(6);
    chk_all(8'h1C);
    i_lnbsi_host.start();
    i_lnbsi_host.send_byte({6'h05, 1'b0, 1'b1}, ak);
    i_lnbsi_host.recv_byte(1'b1, b0);
    i_lnbsi_host.recv_byte(1'b0, b1);
    i_lnbsi_host.stop();
    check("read ack", 11'h1, {10'h000, ak});
    check("read 0", {3'h0, f[4:2], 3'h7, f[1:0]}, {3'h0, b0});
    check("read 1", {3'h0, f[4:2], 3'h7, f[1:0]}, {3'h0, b1});
  endtask : t_read

  task automatic t_foreign;
    logic [2:0] a;
    addr_sel <= 1'b1;
    cyc(6);
    wr(1'b0, 8'h0C, 8'h00, 1, a);
    check("acks", 11'h1, {8'h00, a});
    chk_all(8'h1C);
    wr(1'b1, 8'h0C, 8'h00, 1, a);
    check("acks", 11'h7, {8'h00, a});
    chk_all(8'h0C);
    addr_sel <= 1'b0;
    cyc(6);
  endtask : t_foreign

  task automatic t_lockout;
    logic [2:0] a;
    undervoltage_lockout <= 1'b1;
    cyc(6);
    chk_all(8'h00);
    wr(1'b0, 8'h04, 8'h00, 1, a);
    check("acks", 11'h1, {8'h00, a});
    chk_all(8'h00);
    undervoltage_lockout <= 1'b0;
    cyc(6);
    wr(1'b0, 8'h04, 8'h00, 1, a);
    check("acks", 11'h7, {8'h00, a});
    chk_all(8'h04);
  endtask : t_lockout

  // reset in mid-run must clear a live register, bus usable after
  task automatic t_reset;
    logic [2:0] a;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(4);
    chk_all(8'h00);
    wr(1'b0, 8'h0C, 8'h00, 1, a);
    check("acks", 11'h7, {8'h00, a});
    chk_all(8'h0C);
  endtask : t_reset

  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(4);
    chk_all(8'h00);
    t_levels();
    t_tone();
    t_read(5'h1A);
    t_read(5'h05);
    flt <= 5'h00;
    cyc(6);
    t_foreign();
    t_lockout();
    t_reset();
    conclude();
  end

  // hang guard
  initial begin
    cyc(60000);
    num_errors++;
    conclude();
  end
endmodule : lnbsi_top_test
